/* pkg/reset_config_cfg.svh */
// Offsets, field positions, factory values and timing for the reset configuration latch array
`ifndef RESET_CONFIG_CFG_SVH
`define RESET_CONFIG_CFG_SVH

// Register indices as printed; byte address is four times the index
`define CFG_IDX_PORT_MODES_LOW 3'h0
`define CFG_IDX_PORT_MODES_HIGH 3'h1
`define CFG_IDX_RESET_PIN_P15 3'h2
`define CFG_IDX_BOOT_DEBUG_ECC 3'h3
`define CFG_IDX_WRITE_COUNT 3'h4
`define CFG_IDX_STATUS 3'h5
`define CFG_NUM_REGS 6
`define CFG_IDX_BITS 3

// Field positions in the four latch bytes
`define CFG_EXT_RESET_BIT 7
`define CFG_P15_LSB 0
`define CFG_BOOT_SPEED_BIT 0
`define CFG_DEBUG_LSB 1
`define CFG_ECC_BIT 3
`define CFG_PHASE_LSB 4

// Implemented bits of each latch byte; others read as zero
`define CFG_MASK_RESET_PIN_P15 8'h83
`define CFG_MASK_FULL 8'hFF

// Factory values
`define CFG_DEF_PORT_MODES 8'h00
`define CFG_DEF_RESET_PIN_P15 8'h00
`define CFG_DEF_BOOT_DEBUG_ECC 8'h02

// Status register bit positions
`define CFG_STAT_PENDING_BIT 0
`define CFG_STAT_ECC_SINGLE_BIT 1
`define CFG_STAT_ECC_DOUBLE_BIT 2

// Bus answer timing
`define CFG_WAIT_STATES 1

`endif

/* pkg/reset_config_pkg.sv */
// Types shared by the reset configuration latch array
package reset_config_pkg;

  // Drive state of every pin of one port while in reset
  typedef enum logic [1:0] {
    DRIVE_HIZ_ANALOG = 2'h0,
    DRIVE_HIZ_DIGITAL = 2'h1,
    DRIVE_PULL_UP = 2'h2,
    DRIVE_PULL_DOWN = 2'h3
  } drive_mode_t;

  // Debug port choice
  typedef enum logic [1:0] {
    DEBUG_JTAG5 = 2'h0,
    DEBUG_JTAG4 = 2'h1,
    DEBUG_SWD = 2'h2,
    DEBUG_OFF = 2'h3
  } debug_mode_t;

  // Bus slave states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESPOND = 2'b10
  } bus_state_t;

endpackage : reset_config_pkg

/* src/reset_config_latch_array.sv */
// Reset configuration latch array with APB register access
// Notes on behaviour
// R1: Four bytes of nonvolatile latches hold the configuration taken at each reset.
// R2: Each port has a two-bit drive code: analog high-Z, digital high-Z, pull-up, pull-down.
// R3: One drive code covers every pin of its port, with no per-pin choice.
// R4: The external reset enable bit turns the port-one pin into a reset input when set.
// R5: The boot clock bit selects 12 MHz when clear and 48 MHz when set for the boot oscillator.
// R6: The debug select field picks 5-wire JTAG, 4-wire JTAG, SWD or no debug port.
// R7: The ECC enable bit gives the extra flash area to error codes when set.
// R8: A four-bit field selects the digital clock phase delay.
// R9: Whoever reprograms the latches keeps rewrites few, as their write endurance is limited.
// R10: With ECC on, single-bit errors per eight-byte unit are corrected and double-bit detected.
// R11: Outputs show the latch contents copied on the first enabled clock after reset release and hold until the next reset.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "reset_config_cfg.svh"

module reset_config_latch_array #(
  parameter int NUM_PORTS = 9,
  parameter logic EXT_RESET_DEFAULT = 1'b0,
  parameter logic [3:0] PHASE_DELAY_DEFAULT = 4'h0,
  parameter int WRITE_COUNT_WIDTH = 16
) (
  // Clock, reset and clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic latch_init_n,
  input wire logic pce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash error reports
  input wire logic ecc_single_err,
  input wire logic ecc_double_err,
  output logic ecc_correct_en,
  output logic ecc_error_event,
  // Static configuration outputs
  output logic [2*NUM_PORTS-1:0] port_reset_drive_select,
  output logic ext_reset_pin_enable,
  output logic boot_clock_speed_select,
  output logic [1:0] debug_port_select,
  output logic jtag5_enable,
  output logic jtag4_enable,
  output logic swd_enable,
  output logic flash_ecc_enable,
  output logic [3:0] digital_clock_phase_delay
);

  // Reset-time value of the third latch byte
  localparam logic [7:0] DEF_RESET_PIN_P15 =
    `CFG_DEF_RESET_PIN_P15 | {EXT_RESET_DEFAULT, 7'h00};
  // Reset-time value of the fourth latch byte
  localparam logic [7:0] DEF_BOOT_DEBUG_ECC =
    `CFG_DEF_BOOT_DEBUG_ECC | {PHASE_DELAY_DEFAULT, 4'h0};
  localparam logic [WRITE_COUNT_WIDTH-1:0] COUNT_MAX = '1;

  // Drive code of one port out of the packed latch bytes
  function automatic logic [1:0] port_code(input logic [7:0] lo, input logic [7:0] hi,
                                           input logic [7:0] p15, input int idx);
    logic [1:0] code;
    code = 2'h0;
    if (idx < 4) begin
      code = lo[2*idx +: 2];
    end else if (idx < 8) begin
      code = hi[2*(idx-4) +: 2];
    end else begin
      code = p15[`CFG_P15_LSB +: 2];
    end
    return code;
  endfunction : port_code

  // Byte-lane merge of a write into an eight-bit register
  function automatic logic [7:0] lane_merge(input logic [7:0] old_val, input logic [7:0] wr_val,
                                            input logic lane_en, input logic [7:0] mask);
    return lane_en ? (wr_val & mask) : old_val;
  endfunction : lane_merge

  // Nonvolatile latch bytes
  logic [7:0] nvl_ports_lo_reg;
  logic [7:0] nvl_ports_hi_reg;
  logic [7:0] nvl_pin_p15_reg;
  logic [7:0] nvl_boot_reg;
  // Configuration applied since the last reset
  logic [7:0] app_ports_lo_reg;
  logic [7:0] app_ports_hi_reg;
  logic [7:0] app_pin_p15_reg;
  logic [7:0] app_boot_reg;
  logic loaded_reg;
  // Bus slave state
  reset_config_pkg::bus_state_t state_reg;
  reset_config_pkg::bus_state_t state_next;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  // Status and wear counter
  logic [WRITE_COUNT_WIDTH-1:0] write_count_reg;
  logic ecc_single_seen_reg;
  logic ecc_double_seen_reg;
  logic ecc_event_reg;
  // Registered configuration outputs
  logic [2*NUM_PORTS-1:0] drive_out_reg;
  logic [2:0] debug_onehot_reg;

  // Address decode
  wire logic [`CFG_IDX_BITS-1:0] reg_idx = paddr[`CFG_IDX_BITS+1:2];
  wire logic addr_aligned = (paddr[1:0] == 2'b00);
  wire logic addr_in_map = addr_aligned && (paddr[31:`CFG_IDX_BITS+2] == '0) &&
                           (reg_idx < `CFG_IDX_BITS'(`CFG_NUM_REGS));
  wire logic access = psel && penable;
  wire logic take = pce && access && (state_reg == reset_config_pkg::ST_RESPOND);
  wire logic wr_take = take && pwrite && addr_in_map;
  wire logic nvl_write = wr_take && pstrb[0] && (reg_idx <= `CFG_IDX_BOOT_DEBUG_ECC);
  wire logic stat_write = wr_take && pstrb[0] && (reg_idx == `CFG_IDX_STATUS);
  wire logic [7:0] wr_byte = pwdata[7:0];

  // Latch byte write strobes
  wire logic wr_lo = nvl_write && (reg_idx == `CFG_IDX_PORT_MODES_LOW);
  wire logic wr_hi = nvl_write && (reg_idx == `CFG_IDX_PORT_MODES_HIGH);
  wire logic wr_p15 = nvl_write && (reg_idx == `CFG_IDX_RESET_PIN_P15);
  wire logic wr_boot = nvl_write && (reg_idx == `CFG_IDX_BOOT_DEBUG_ECC);

  // Applied configuration differs from the stored latches
  wire logic reload_pending = (nvl_ports_lo_reg != app_ports_lo_reg) ||
                              (nvl_ports_hi_reg != app_ports_hi_reg) ||
                              (nvl_pin_p15_reg != app_pin_p15_reg) ||
                              (nvl_boot_reg != app_boot_reg);

  // Fields of the applied configuration
  wire logic ecc_on = app_boot_reg[`CFG_ECC_BIT];
  wire logic [1:0] debug_sel = app_boot_reg[`CFG_DEBUG_LSB +: 2];
  wire logic [2:0] debug_decode =
    (debug_sel == reset_config_pkg::DEBUG_JTAG5) ? 3'b001 :
    (debug_sel == reset_config_pkg::DEBUG_JTAG4) ? 3'b010 :
    (debug_sel == reset_config_pkg::DEBUG_SWD) ? 3'b100 : 3'b000;

  // Flash error reports count only with ECC on; clear loses to a new report
  wire logic single_set = ecc_on && ecc_single_err;
  wire logic double_set = ecc_on && ecc_double_err;
  wire logic single_clr = stat_write && wr_byte[`CFG_STAT_ECC_SINGLE_BIT];
  wire logic double_clr = stat_write && wr_byte[`CFG_STAT_ECC_DOUBLE_BIT];

  // Read data mux
  wire logic [7:0] rd_status = {5'h00, ecc_double_seen_reg, ecc_single_seen_reg, reload_pending};
  wire logic [31:0] rd_word =
    (reg_idx == `CFG_IDX_PORT_MODES_LOW) ? {24'h00_0000, nvl_ports_lo_reg} :
    (reg_idx == `CFG_IDX_PORT_MODES_HIGH) ? {24'h00_0000, nvl_ports_hi_reg} :
    (reg_idx == `CFG_IDX_RESET_PIN_P15) ? {24'h00_0000, nvl_pin_p15_reg} :
    (reg_idx == `CFG_IDX_BOOT_DEBUG_ECC) ? {24'h00_0000, nvl_boot_reg} :
    (reg_idx == `CFG_IDX_WRITE_COUNT) ? 32'(write_count_reg) :
    {24'h00_0000, rd_status};

  // Per-port drive codes laid out for the port blocks
  logic [2*NUM_PORTS-1:0] drive_next;
  always_comb begin
    drive_next = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      drive_next[2*p +: 2] = port_code(app_ports_lo_reg, app_ports_hi_reg,
                                       app_pin_p15_reg, p); // R2 R3
    end
  end

  // Bus state sequencing: one wait state per transfer
  always_comb begin
    case (state_reg)
      reset_config_pkg::ST_IDLE: begin
        state_next = access ? reset_config_pkg::ST_RESPOND : reset_config_pkg::ST_IDLE;
      end
      reset_config_pkg::ST_RESPOND: begin
        state_next = reset_config_pkg::ST_IDLE;
      end
      default: begin
        state_next = reset_config_pkg::ST_IDLE;
      end
    endcase
  end

  // Latch cells, initialised to factory values only by their own reset
  always_ff @(posedge pclk or negedge latch_init_n) begin
    if (!latch_init_n) begin
      nvl_ports_lo_reg <= `CFG_DEF_PORT_MODES; // R1
      nvl_ports_hi_reg <= `CFG_DEF_PORT_MODES;
      nvl_pin_p15_reg <= DEF_RESET_PIN_P15; // R4
      nvl_boot_reg <= DEF_BOOT_DEBUG_ECC; // R5 R6 R7 R8
    end else if (pce) begin
      nvl_ports_lo_reg <= lane_merge(nvl_ports_lo_reg, wr_byte, wr_lo, `CFG_MASK_FULL);
      nvl_ports_hi_reg <= lane_merge(nvl_ports_hi_reg, wr_byte, wr_hi, `CFG_MASK_FULL);
      nvl_pin_p15_reg <= lane_merge(nvl_pin_p15_reg, wr_byte, wr_p15, `CFG_MASK_RESET_PIN_P15);
      nvl_boot_reg <= lane_merge(nvl_boot_reg, wr_byte, wr_boot, `CFG_MASK_FULL);
    end
  end

  // Wear counter of latch rewrites, saturating
  always_ff @(posedge pclk or negedge latch_init_n) begin
    if (!latch_init_n) begin
      write_count_reg <= '0;
    end else if (pce && nvl_write && (write_count_reg != COUNT_MAX)) begin
      write_count_reg <= write_count_reg + 1'b1; // R9
    end
  end

  // Applied configuration: factory values in reset, one copy after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      app_ports_lo_reg <= `CFG_DEF_PORT_MODES;
      app_ports_hi_reg <= `CFG_DEF_PORT_MODES;
      app_pin_p15_reg <= DEF_RESET_PIN_P15;
      app_boot_reg <= DEF_BOOT_DEBUG_ECC;
      loaded_reg <= 1'b0;
    end else if (pce && !loaded_reg) begin
      app_ports_lo_reg <= nvl_ports_lo_reg; // R11
      app_ports_hi_reg <= nvl_ports_hi_reg;
      app_pin_p15_reg <= nvl_pin_p15_reg;
      app_boot_reg <= nvl_boot_reg;
      loaded_reg <= 1'b1;
    end
  end

  // Configuration output flops, following the applied copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_out_reg <= '0;
      debug_onehot_reg <= 3'b010;
    end else if (pce) begin
      drive_out_reg <= drive_next; // R2 R3
      debug_onehot_reg <= debug_decode; // R6
    end
  end

  // Flash error capture and event pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecc_single_seen_reg <= 1'b0;
      ecc_double_seen_reg <= 1'b0;
      ecc_event_reg <= 1'b0;
    end else if (pce) begin
      ecc_single_seen_reg <= single_set || (ecc_single_seen_reg && !single_clr); // R10
      ecc_double_seen_reg <= double_set || (ecc_double_seen_reg && !double_clr); // R10
      ecc_event_reg <= single_set || double_set; // R10
    end
  end

  // APB answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= reset_config_pkg::ST_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else if (pce) begin
      state_reg <= state_next;
      pready_reg <= (state_reg == reset_config_pkg::ST_IDLE) && access;
      pslverr_reg <= (state_reg == reset_config_pkg::ST_IDLE) && access && !addr_in_map;
      prdata_reg <= ((state_reg == reset_config_pkg::ST_IDLE) && access && !pwrite &&
                     addr_in_map) ? rd_word : 32'h0000_0000;
    end
  end

  // Outputs
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign port_reset_drive_select = drive_out_reg;
  assign ext_reset_pin_enable = app_pin_p15_reg[`CFG_EXT_RESET_BIT]; // R4
  assign boot_clock_speed_select = app_boot_reg[`CFG_BOOT_SPEED_BIT]; // R5
  assign debug_port_select = debug_sel; // R6
  assign jtag5_enable = debug_onehot_reg[0];
  assign jtag4_enable = debug_onehot_reg[1];
  assign swd_enable = debug_onehot_reg[2];
  assign flash_ecc_enable = ecc_on; // R7
  assign ecc_correct_en = ecc_on; // R10
  assign ecc_error_event = ecc_event_reg;
  assign digital_clock_phase_delay = app_boot_reg[`CFG_PHASE_LSB +: 4]; // R8

endmodule : reset_config_latch_array
`default_nettype wire

/* dv/cfg_props_properties.sv */
// Port assertions for the reset configuration latch array
`timescale 1ns/1ns
`default_nettype none
module cfg_props #(parameter int NUM_PORTS = 9) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Flash errors and configuration
  input wire logic ecc_single_err,
  input wire logic ecc_double_err,
  input wire logic ecc_error_event,
  input wire logic [2*NUM_PORTS-1:0] port_reset_drive_select,
  input wire logic ext_reset_pin_enable,
  input wire logic boot_clock_speed_select,
  input wire logic [1:0] debug_port_select,
  input wire logic jtag5_enable,
  input wire logic jtag4_enable,
  input wire logic swd_enable,
  input wire logic flash_ecc_enable,
  input wire logic [3:0] digital_clock_phase_delay
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Transfer phases and a settled reset release
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_up;
    presetn [*4];
  endsequence
  property p_wait;
    s_setup ##1 s_access |-> !pready ##1 pready;
  endproperty
  a_wait: assert property (p_wait) else $error("answer not after one wait state");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready held too long");
  property p_err;
    pready |-> pslverr == (paddr > 32'h0000_0014 || paddr[1:0] != 2'h0);
  endproperty
  a_err: assert property (p_err) else $error("wrong error answer");
  property p_quiet;
    !pready || pslverr |-> prdata == 32'h0000_0000;
  endproperty
  a_quiet: assert property (p_quiet) else $error("read data outside answer");
  property p_onehot;
    {jtag5_enable, jtag4_enable, swd_enable} == 3'b100 >> $past(debug_port_select);
  endproperty
  a_onehot: assert property (p_onehot) else $error("debug decode wrong");
  property p_hold;
    s_up |-> $stable({port_reset_drive_select, ext_reset_pin_enable, boot_clock_speed_select,
      debug_port_select, flash_ecc_enable, digital_clock_phase_delay});
  endproperty
  a_hold: assert property (p_hold) else $error("configuration moved");
  property p_ecc_on;
    flash_ecc_enable && (ecc_single_err || ecc_double_err) |=> ecc_error_event;
  endproperty
  a_ecc_on: assert property (p_ecc_on) else $error("error event missing");
  property p_ecc_off;
    !(flash_ecc_enable && (ecc_single_err || ecc_double_err)) |=> !ecc_error_event;
  endproperty
  a_ecc_off: assert property (p_ecc_off) else $error("stray error event");
endmodule : cfg_props
bind reset_config_latch_array cfg_props #(.NUM_PORTS(NUM_PORTS)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ecc_single_err(ecc_single_err),
  .ecc_double_err(ecc_double_err), .ecc_error_event(ecc_error_event),
  .port_reset_drive_select(port_reset_drive_select),
  .ext_reset_pin_enable(ext_reset_pin_enable),
  .boot_clock_speed_select(boot_clock_speed_select), .debug_port_select(debug_port_select),
  .jtag5_enable(jtag5_enable), .jtag4_enable(jtag4_enable), .swd_enable(swd_enable),
  .flash_ecc_enable(flash_ecc_enable), .digital_clock_phase_delay(digital_clock_phase_delay));
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the reset configuration latch array
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, latch_init_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ecc_single_err = 1'b0, ecc_double_err = 1'b0;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, rnd = 32'h0000_efaa;
  logic pready, pslverr, ecc_correct_en, ecc_error_event, ext_en, speed, jt5, jt4, swd, ecc_en;
  logic [17:0] drive;
  logic [1:0] dbg;
  logic [3:0] phase;
  logic [33:0] note;
  logic [33:0] notes[$];
  logic [7:0] b[4], nb[4];
  int mismatches = 0, tests_run = 0;
  reset_config_latch_array u_dut (.pclk(pclk), .presetn(presetn), .latch_init_n(latch_init_n),
    .pce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ecc_single_err(ecc_single_err), .ecc_double_err(ecc_double_err),
    .ecc_correct_en(ecc_correct_en), .ecc_error_event(ecc_error_event),
    .port_reset_drive_select(drive), .ext_reset_pin_enable(ext_en),
    .boot_clock_speed_select(speed), .debug_port_select(dbg), .jtag5_enable(jt5),
    .jtag4_enable(jt4), .swd_enable(swd), .flash_ecc_enable(ecc_en),
    .digital_clock_phase_delay(phase));
  // Clock
  initial forever #5 pclk = ~pclk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic test_done();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  // One bus transfer; the expected answer goes on the note queue
  task automatic xfer(input logic wr, input logic [31:0] a, d, input logic err,
                      input logic [7:0] e);
    notes.push_back({~wr, err, 24'h00_0000, e});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // Answer watcher
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (notes.size() == 0) begin
        mismatches++;
        $display("mismatch answer expected none seen pready");
      end else begin
        note = notes.pop_front();
        chk("pslverr", 32'(pslverr), 32'(note[32]));
        if (note[33]) chk("prdata", prdata, note[31:0]);
      end
    end
  end
  task automatic cfg_chk();
    chk("drive", 32'(drive), 32'({b[2][1:0], b[1], b[0]}));
    chk("ext_reset", 32'(ext_en), 32'(b[2][7]));
    chk("boot_speed", 32'(speed), 32'(b[3][0]));
    chk("debug", 32'(dbg), 32'(b[3][2:1]));
    chk("debug_onehot", 32'({jt5, jt4, swd}), 32'(3'b100 >> b[3][2:1]));
    chk("ecc", 32'(ecc_en), 32'(b[3][3]));
    chk("ecc_correct", 32'(ecc_correct_en), 32'(b[3][3]));
    chk("phase", 32'(phase), 32'(b[3][7:4]));
  endtask : cfg_chk
  // Main sequence
  initial begin
    b = '{8'h00, 8'h00, 8'h00, 8'h02};
    repeat (4) @(posedge pclk);
    latch_init_n <= 1'b1;
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    cfg_chk();
    for (int i = 0; i < 4; i++) xfer(1'b0, 32'(4 * i), 32'h0, 1'b0, b[i]);
    xfer(1'b0, 32'h0000_0018, 32'h0, 1'b1, 8'h00);
    xfer(1'b1, 32'h0000_0002, 32'h0, 1'b1, 8'h00);
    for (int d = 0; d < 4; d++) begin
      for (int i = 0; i < 4; i++) begin
        rnd = lfsr(rnd);
        if (i == 3) rnd[3:1] = {d[0], d[1:0]};
        nb[i] = (i == 2) ? rnd[7:0] & 8'h83 : rnd[7:0];
        xfer(1'b1, 32'(4 * i), rnd, 1'b0, 8'h00);
        xfer(1'b0, 32'(4 * i), 32'h0, 1'b0, nb[i]);
      end
      cfg_chk();
      xfer(1'b0, 32'h0000_0010, 32'h0, 1'b0, 8'(4 * (d + 1)));
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      b = nb;
      repeat (3) @(posedge pclk);
      cfg_chk();
      ecc_single_err <= ~d[1];
      ecc_double_err <= d[1];
      @(posedge pclk);
      ecc_single_err <= 1'b0;
      ecc_double_err <= 1'b0;
      @(posedge pclk);
      chk("ecc_event", 32'(ecc_error_event), 32'(b[3][3]));
      xfer(1'b0, 32'h0000_0014, 32'h0, 1'b0, {5'h00, d[0] & d[1], d[0] & ~d[1], 1'b0});
      xfer(1'b1, 32'h0000_0014, 32'h0000_0006, 1'b0, 8'h00);
      xfer(1'b0, 32'h0000_0014, 32'h0, 1'b0, 8'h00);
    end
    test_done();
  end
  // Watchdog
  initial begin
    #100000;
    mismatches++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
